// [hdl/ahpg_pkg.sv]
// Package for the adaptive high-side PWM gate sequencer.
// Assumes one bridge-driver clock at 200 MHz drives all users of these constants.
package ahpg_pkg;
   localparam int CODE_W = 6;
   localparam int TIME_W = 12;
   localparam logic [5:0] MIN_CODE = 6'h00;
   localparam logic [5:0] MAX_CODE = 6'h3F;
   localparam logic [5:0] RST_CODE = 6'h00;
   localparam logic [11:0] RST_COUNT = 12'h000;
   localparam logic [1:0] SYNC_RST = 2'h0;

   // Sequencer phases.
   typedef enum logic [3:0] {
      AHPG_IDLE   = 4'h0,
      AHPG_GUARD  = 4'h1,
      AHPG_PCHG   = 4'h2,
      AHPG_CHG    = 4'h3,
      AHPG_POST   = 4'h4,
      AHPG_ON     = 4'h5,
      AHPG_SYM    = 4'h6,
      AHPG_PDCHG  = 4'h7,
      AHPG_DCHG   = 4'h8,
      AHPG_OFF    = 4'h9
   } ahpg_state_t;

   // Gate command to the external driver stage.
   typedef struct packed {
      logic hs_src;
      logic hs_sink;
      logic [5:0] hs_code;
      logic ls_src;
      logic ls_sink;
      logic [5:0] ls_code;
   } ahpg_gate_t;

   // Timing configuration, all in bridge-driver clock cycles.
   typedef struct packed {
      logic [11:0] fw_guard_time;
      logic [11:0] active_guard_time;
      logic [11:0] precharge_duration;
      logic [11:0] predischarge_duration;
      logic [11:0] vds_filter_time;
      logic [11:0] turn_on_delay_target;
      logic [11:0] turn_off_delay_target;
   } ahpg_timing_t;

   // Current configuration codes.
   typedef struct packed {
      logic [5:0] charge_current;
      logic [5:0] discharge_current;
      logic [5:0] freewheel_gate_current;
      logic [5:0] max_gate_current;
      logic [5:0] precharge_init_current;
      logic [5:0] predischarge_init_current;
   } ahpg_current_t;
endpackage

// [hdl/ahpg_sequencer.sv]
// Adaptive high-side PWM gate sequencer for one half-bridge.
// Assumes pwm_input and the switch-node comparators are asynchronous pins;
// configuration inputs are quasi-static and come from the clock domain.
`timescale 1ns/10ps
module ahpg_sequencer
   import ahpg_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_pwm_input,
   input wire logic i_switch_node_high_thresh,
   input wire logic i_switch_node_low_thresh,
   input wire logic i_bridge_pwm_enable_set,
   input wire logic i_active_freewheel_sel,
   input wire logic [1:0] i_adaptive_gate_mode,
   input wire logic i_adapt_filter_en,
   input wire logic i_adapt_step_size,
   input wire ahpg_timing_t i_timing,
   input wire ahpg_current_t i_current,
   output ahpg_gate_t o_gate,
   output logic [5:0] o_precharge_current,
   output logic [5:0] o_predischarge_current,
   output logic [11:0] o_eff_turn_on_delay,
   output logic [11:0] o_eff_turn_off_delay,
   output ahpg_state_t o_phase
);
   logic [2:0] pwm_sync, shh_sync, shl_sync;
   logic pwm_level, shh, shl, rise, fall, adapt_on, ls_fw_on;
   ahpg_state_t state, next_state;
   logic [11:0] phase_cnt, guard_cnt, filt_cnt, delay_cnt, meas_on, meas_off;
   logic [5:0] pchg_code, pdchg_code, post_code, next_post_code;
   logic [1:0] on_hist, off_hist;
   logic on_done, off_done, off_taken;

   // Three-stage synchronisers; a change counts once stages two and three agree.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         pwm_sync <= 3'h0;
         shh_sync <= 3'h0;
         shl_sync <= 3'h0;
         pwm_level <= 1'b0;
         shh <= 1'b0;
         shl <= 1'b0;
      end else begin
         pwm_sync <= {pwm_sync[1:0], i_pwm_input};
         shh_sync <= {shh_sync[1:0], i_switch_node_high_thresh};
         shl_sync <= {shl_sync[1:0], i_switch_node_low_thresh};
         if (pwm_sync[1] == pwm_sync[2]) begin
            pwm_level <= pwm_sync[2];
         end
         if (shh_sync[1] == shh_sync[2]) begin
            shh <= shh_sync[2];
         end
         if (shl_sync[1] == shl_sync[2]) begin
            shl <= shl_sync[2];
         end
      end
   end

   assign rise = (pwm_sync[1] == pwm_sync[2]) && pwm_sync[2] && !pwm_level;
   assign fall = (pwm_sync[1] == pwm_sync[2]) && !pwm_sync[2] && pwm_level;
   assign adapt_on = i_adaptive_gate_mode[1];
   assign next_post_code = (post_code < i_current.max_gate_current) ?
                           post_code + 6'h01 : i_current.max_gate_current;

   // Phase sequencing. A new PWM edge always restarts the matching sequence.
   always_comb begin
      next_state = state;
      if (rise) begin
         next_state = i_active_freewheel_sel ? AHPG_GUARD : AHPG_PCHG;
      end else if (fall) begin
         next_state = i_active_freewheel_sel ? AHPG_SYM : AHPG_PDCHG;
      end else begin
         unique case (state)
            AHPG_GUARD: if (phase_cnt >= i_timing.fw_guard_time) next_state = AHPG_PCHG;
            AHPG_PCHG: if (phase_cnt >= i_timing.precharge_duration) next_state = AHPG_CHG;
            AHPG_CHG: if (shh) next_state = AHPG_POST;
            AHPG_POST: if (filt_cnt >= i_timing.vds_filter_time) next_state = AHPG_ON;
            AHPG_SYM: if (phase_cnt >= i_timing.fw_guard_time) next_state = AHPG_PDCHG;
            AHPG_PDCHG: if (phase_cnt >= i_timing.predischarge_duration) begin
               next_state = AHPG_DCHG;
            end
            AHPG_DCHG: if (guard_cnt >= i_timing.active_guard_time) next_state = AHPG_OFF;
            default: next_state = state;
         endcase
      end
   end

   // State register and per-phase counter; counts are whole clock cycles.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= AHPG_IDLE;
         phase_cnt <= RST_COUNT;
      end else begin
         state <= next_state;
         if (next_state != state || rise || fall) begin
            phase_cnt <= 12'h001;
         end else if (phase_cnt != 12'hFFF) begin
            phase_cnt <= phase_cnt + 12'h001;
         end
      end
   end

   // Active guard starts on entry to pre-discharge and runs through pre-discharge and discharge.
   // The filter counter spans post-charge and the low-side freewheel window.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         guard_cnt <= RST_COUNT;
         filt_cnt <= RST_COUNT;
         ls_fw_on <= 1'b0;
      end else begin
         if (next_state == AHPG_PDCHG && state != AHPG_PDCHG) begin
            guard_cnt <= 12'h001;
         end else if (guard_cnt != 12'hFFF) begin
            guard_cnt <= guard_cnt + 12'h001;
         end
         if ((next_state == AHPG_POST && state != AHPG_POST) ||
             (next_state == AHPG_OFF && state != AHPG_OFF)) begin
            filt_cnt <= 12'h001;
         end else if (filt_cnt != 12'hFFF) begin
            filt_cnt <= filt_cnt + 12'h001;
         end
         // Low-side freewheel charge only in active mode and while node is low.
         ls_fw_on <= (state == AHPG_OFF) && i_active_freewheel_sel && shl &&
                     (filt_cnt < i_timing.vds_filter_time);
      end
   end

   // Delay measurement from start of pre-charge or pre-discharge to the comparator.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         delay_cnt <= RST_COUNT;
         on_done <= 1'b0;
         off_done <= 1'b0;
         meas_on <= RST_COUNT;
         meas_off <= RST_COUNT;
         off_taken <= 1'b0;
      end else begin
         on_done <= 1'b0;
         off_done <= 1'b0;
         if ((next_state == AHPG_PCHG && state != AHPG_PCHG) ||
             (next_state == AHPG_PDCHG && state != AHPG_PDCHG)) begin
            delay_cnt <= 12'h001;
         end else if (delay_cnt != 12'hFFF) begin
            delay_cnt <= delay_cnt + 12'h001;
         end
         if (state == AHPG_CHG && shh) begin
            meas_on <= delay_cnt;
            on_done <= 1'b1;
         end
         if (next_state == AHPG_PDCHG && state != AHPG_PDCHG) begin
            off_taken <= 1'b0;
         end else if ((state == AHPG_PDCHG || state == AHPG_DCHG) && shl && !off_taken) begin
            meas_off <= delay_cnt;
            off_taken <= 1'b1; // Only the first low-threshold sample counts.
         end
         if (state == AHPG_DCHG && next_state == AHPG_OFF) begin
            off_done <= 1'b1;
         end
      end
   end

   // Pre-charge adaptation with clamp, optional filtering and step size.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         pchg_code <= RST_CODE;
         on_hist <= 2'h0;
      end else if (i_bridge_pwm_enable_set) begin
         pchg_code <= (i_current.precharge_init_current < i_current.max_gate_current) ?
                      i_current.precharge_init_current : i_current.max_gate_current;
         on_hist <= 2'h0;
      end else if (on_done && adapt_on) begin
         on_hist <= {meas_on > i_timing.turn_on_delay_target,
                     meas_on < i_timing.turn_on_delay_target};
         if ((meas_on > i_timing.turn_on_delay_target) &&
             (!i_adapt_filter_en || on_hist[1])) begin
            pchg_code <= step_up(pchg_code, i_adapt_step_size, i_current.max_gate_current);
         end else if ((meas_on < i_timing.turn_on_delay_target) &&
                      (!i_adapt_filter_en || on_hist[0])) begin
            pchg_code <= step_dn(pchg_code, i_adapt_step_size);
         end
      end
   end

   // Pre-discharge adaptation mirrors the pre-charge scheme.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         pdchg_code <= RST_CODE;
         off_hist <= 2'h0;
      end else if (i_bridge_pwm_enable_set) begin
         pdchg_code <= (i_current.predischarge_init_current < i_current.max_gate_current) ?
                       i_current.predischarge_init_current : i_current.max_gate_current;
         off_hist <= 2'h0;
      end else if (off_done && adapt_on) begin
         off_hist <= {meas_off > i_timing.turn_off_delay_target,
                      meas_off < i_timing.turn_off_delay_target};
         if ((meas_off > i_timing.turn_off_delay_target) &&
             (!i_adapt_filter_en || off_hist[1])) begin
            pdchg_code <= step_up(pdchg_code, i_adapt_step_size, i_current.max_gate_current);
         end else if ((meas_off < i_timing.turn_off_delay_target) &&
                      (!i_adapt_filter_en || off_hist[0])) begin
            pdchg_code <= step_dn(pdchg_code, i_adapt_step_size);
         end
      end
   end

   // Saturating steps keep the codes inside the legal range.
   function automatic logic [5:0] step_up(input logic [5:0] c, input logic two,
                                          input logic [5:0] mx);
      logic [6:0] s;
      s = {1'b0, c} + (two ? 7'h02 : 7'h01);
      step_up = (s > {1'b0, mx}) ? mx : s[5:0];
   endfunction

   function automatic logic [5:0] step_dn(input logic [5:0] c, input logic two);
      logic [5:0] d;
      d = two ? 6'h02 : 6'h01;
      step_dn = (c < MIN_CODE + d) ? MIN_CODE : c - d;
   endfunction

   // Gate command outputs, all registered.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_gate <= '0;
         post_code <= RST_CODE;
      end else begin
         o_gate <= '0;
         unique case (next_state)
            AHPG_GUARD: begin
               o_gate.ls_sink <= 1'b1;
               o_gate.ls_code <= i_current.freewheel_gate_current;
            end
            AHPG_PCHG: begin
               o_gate.hs_src <= 1'b1;
               o_gate.hs_code <= pchg_code;
            end
            AHPG_CHG: begin
               o_gate.hs_src <= 1'b1;
               o_gate.hs_code <= i_current.charge_current;
               post_code <= i_current.charge_current;
            end
            AHPG_POST, AHPG_ON: begin
               o_gate.hs_src <= 1'b1;
               post_code <= next_post_code;
               o_gate.hs_code <= next_post_code;
            end
            AHPG_SYM: begin
               o_gate.hs_src <= 1'b1;
               o_gate.hs_code <= post_code;
            end
            AHPG_PDCHG: begin
               o_gate.hs_sink <= 1'b1;
               o_gate.hs_code <= pdchg_code;
            end
            AHPG_DCHG: begin
               o_gate.hs_sink <= 1'b1;
               o_gate.hs_code <= i_current.discharge_current;
            end
            default: begin
               o_gate.ls_src <= ls_fw_on && i_active_freewheel_sel;
               o_gate.ls_code <= ls_fw_on ? i_current.freewheel_gate_current : 6'h00;
            end
         endcase
      end
   end

   // Status outputs.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_precharge_current <= RST_CODE;
         o_predischarge_current <= RST_CODE;
         o_eff_turn_on_delay <= RST_COUNT;
         o_eff_turn_off_delay <= RST_COUNT;
         o_phase <= AHPG_IDLE;
      end else begin
         o_precharge_current <= pchg_code;
         o_predischarge_current <= pdchg_code;
         o_eff_turn_on_delay <= meas_on;
         o_eff_turn_off_delay <= meas_off;
         o_phase <= state;
      end
   end

   // Passive freewheel never turns the low side on.
   passive_ls_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_active_freewheel_sel |=> !o_gate.ls_src) else $error("low side on in passive");
   // Pre-charge code stays within the maximum.
   pchg_clamp_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_bridge_pwm_enable_set |=> pchg_code <= i_current.max_gate_current)
      else $error("pre-charge code above max");
   // Rise in active mode enters guard.
   guard_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      rise && i_active_freewheel_sel |=> state == AHPG_GUARD) else $error("no guard");
   // Rise in passive mode goes straight to pre-charge.
   passive_rise_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      rise && !i_active_freewheel_sel |=> state == AHPG_PCHG) else $error("guard not skipped");
   // Fall in passive mode skips the symmetrisation delay.
   passive_fall_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      fall && !i_active_freewheel_sel |=> state == AHPG_PDCHG) else $error("fall guard");
   // Enable load picks the smaller of the initial code and the maximum.
   init_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_bridge_pwm_enable_set |=> pchg_code == (($past(i_current.precharge_init_current) <
      $past(i_current.max_gate_current)) ? $past(i_current.precharge_init_current) :
      $past(i_current.max_gate_current))) else $error("init load wrong");
   // No adaptation when mode bit is clear.
   no_adapt_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !adapt_on && !i_bridge_pwm_enable_set |=> $stable(pchg_code))
      else $error("adapted while disabled");
   // Charge phase ends once high threshold seen.
   chg_end_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state == AHPG_CHG && shh && !rise && !fall |=> state == AHPG_POST)
      else $error("charge did not end");
endmodule

// [sim/ahpg_bridge_model.sv]
// Behavioural half-bridge seen from the gate pins, with its switch-node comparators.
// Assumes the gate command arrives registered on the same reference clock.
`timescale 1ns/10ps
module ahpg_bridge_model
   import ahpg_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire ahpg_gate_t i_gate,
   input wire logic [7:0] i_rise_dly,
   input wire logic [7:0] i_fall_dly,
   output logic o_node_high,
   output logic o_node_low
);
   logic [7:0] cnt;
   logic node;

   // The node moves only after the gate has been driven for the set number of cycles.
   // A slow MOSFET is what makes the measured delays long, so both delays are inputs.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cnt <= 8'h00;
         node <= 1'b0;
      end else if ((i_gate.hs_src && !node) || (i_gate.hs_sink && node)) begin
         if (cnt >= (node ? i_fall_dly : i_rise_dly)) begin
            node <= !node;
            cnt <= 8'h00;
         end else begin
            cnt <= cnt + 8'h01;
         end
      end else begin
         cnt <= 8'h00;
      end
   end

   // The band between the thresholds is not modelled, so the comparators are complementary.
   assign o_node_high = node;
   assign o_node_low = !node;
endmodule

// [sim/test_adaptive_hs_pwm_gate_sequencer.sv]
// Self-checking bench for the adaptive high-side PWM gate sequencer.
// Assumes the bridge model file and a 200 MHz reference clock.
`timescale 1ns/10ps
module test_adaptive_hs_pwm_gate_sequencer
   import ahpg_pkg::*;
;
   localparam logic [11:0] LONG_T = 12'h002;
   localparam logic [11:0] SHORT_T = 12'h0C8;
   // The node flips one cycle after the model count expires; sync, agreement and capture add five.
   localparam logic [11:0] ON_DLY = 12'h012;
   localparam logic [11:0] OFF_DLY = 12'h00E;
   logic [11:0] eon, eoff;
   logic clk, rst, pwm, hi_th, lo_th, en_set, afw, filt, step;
   logic [1:0] mode;
   ahpg_timing_t tim;
   ahpg_current_t cur;
   ahpg_gate_t gate;
   ahpg_state_t phase;
   logic [5:0] pc, pd, exp_pc, exp_pd, pc_seen, ch_seen, pd_seen, dc_seen;
   logic seq_bad, post_bad, fw_seen;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int dur[16];
   int first[16];

   ahpg_sequencer uut (
      .i_ref_clk(clk), .i_rst(rst), .i_pwm_input(pwm), .i_switch_node_high_thresh(hi_th),
      .i_switch_node_low_thresh(lo_th), .i_bridge_pwm_enable_set(en_set),
      .i_active_freewheel_sel(afw), .i_adaptive_gate_mode(mode), .i_adapt_filter_en(filt),
      .i_adapt_step_size(step), .i_timing(tim), .i_current(cur), .o_gate(gate),
      .o_precharge_current(pc), .o_predischarge_current(pd), .o_eff_turn_on_delay(eon),
      .o_eff_turn_off_delay(eoff), .o_phase(phase));

   ahpg_bridge_model bridge (
      .i_ref_clk(clk), .i_rst(rst), .i_gate(gate), .i_rise_dly(8'h0C), .i_fall_dly(8'h08),
      .o_node_high(hi_th), .o_node_low(lo_th));

   // Free-running reference clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // A hang is cut short well beyond the thousand or so cycles the run needs.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         bad_count = bad_count + 1;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Step a code once, clamped to the lowest code and the maximum code.
   function automatic logic [5:0] nxt(input logic [5:0] c, input int dir);
      logic [6:0] s;
      logic [6:0] d;
      s = {1'b0, c};
      d = step ? 7'h02 : 7'h01;
      if (dir > 0) begin
         s = s + d;
         if (s > {1'b0, cur.max_gate_current}) s = {1'b0, cur.max_gate_current};
      end else if (dir < 0) begin
         s = (s < d) ? 7'h00 : s - d;
      end
      return s[5:0];
   endfunction

   task automatic expect_codes(input int on_dir, input int off_dir);
      exp_pc = nxt(exp_pc, on_dir);
      exp_pd = nxt(exp_pd, off_dir);
      chk(16'(pc), 16'(exp_pc));
      chk(16'(pd), 16'(exp_pd));
   endtask

   task automatic set_cfg(input logic a, input logic [1:0] m, input logic f, input logic s);
      @(negedge clk);
      afw = a;
      mode = m;
      filt = f;
      step = s;
   endtask

   task automatic load_codes(input logic [5:0] pi, input logic [5:0] pdi);
      @(negedge clk);
      cur.precharge_init_current = pi;
      cur.predischarge_init_current = pdi;
      en_set = 1'b1;
      @(negedge clk);
      en_set = 1'b0;
      exp_pc = (pi < cur.max_gate_current) ? pi : cur.max_gate_current;
      exp_pd = (pdi < cur.max_gate_current) ? pdi : cur.max_gate_current;
      repeat (3) @(posedge clk);
      #1;
      expect_codes(0, 0);
   endtask

   // Drive one PWM edge and record phase lengths and the gate command of each phase.
   // The phase output lags the gate by one cycle, so the previous gate sample is used.
   task automatic run_edge(input logic lvl);
      ahpg_gate_t gp;
      logic [5:0] prevc;
      int k;
      int tail;
      int p;
      tail = 0;
      prevc = 6'h00;
      gp = gate;
      seq_bad = 1'b0;
      post_bad = 1'b0;
      fw_seen = 1'b0;
      for (p = 0; p < 16; p++) begin
         dur[p] = 0;
         first[p] = 999;
      end
      @(negedge clk);
      pwm = lvl;
      for (k = 0; k < 600 && tail < 24; k++) begin
         @(posedge clk);
         #1;
         p = int'(phase);
         dur[p]++;
         if (first[p] == 999) first[p] = k;
         case (phase)
            AHPG_GUARD: if (gp.hs_src || !gp.ls_sink) seq_bad = 1'b1;
            AHPG_PCHG: pc_seen = gp.hs_src ? gp.hs_code : 6'h3F;
            AHPG_CHG: ch_seen = gp.hs_code;
            AHPG_POST: begin
               if (gp.hs_code !== ((prevc == cur.max_gate_current) ? prevc : prevc + 6'h01))
                  post_bad = 1'b1;
            end
            AHPG_PDCHG: pd_seen = gp.hs_sink ? gp.hs_code : 6'h3F;
            AHPG_DCHG: dc_seen = gp.hs_code;
            AHPG_OFF: if (gp.ls_src && gp.ls_code === cur.freewheel_gate_current) fw_seen = 1'b1;
            default: ;
         endcase
         if (gp.ls_src && (!afw || phase inside {AHPG_GUARD, AHPG_SYM, AHPG_PDCHG, AHPG_DCHG}))
            seq_bad = 1'b1;
         if (phase == (lvl ? AHPG_ON : AHPG_OFF)) tail++;
         prevc = gp.hs_code;
         gp = gate;
      end
   endtask

   // One full PWM period, judging phase order, lengths and gate codes.
   task automatic pwm_cycle(input logic [11:0] ton, input logic [11:0] toff);
      logic ord;
      @(negedge clk);
      tim.turn_on_delay_target = ton;
      tim.turn_off_delay_target = toff;
      run_edge(1'b1);
      ord = first[AHPG_PCHG] < first[AHPG_CHG] && first[AHPG_CHG] < first[AHPG_POST];
      chk(16'(ord && (!afw || first[AHPG_GUARD] < first[AHPG_PCHG])), 16'h0001);
      chk(16'(dur[AHPG_GUARD]), afw ? 16'(tim.fw_guard_time) : 16'h0000);
      chk(16'(dur[AHPG_PCHG]), 16'(tim.precharge_duration));
      chk(16'(pc_seen), 16'(exp_pc));
      chk(16'(ch_seen), 16'(cur.charge_current));
      chk(16'(post_bad), 16'h0000);
      chk(16'(dur[AHPG_POST]), 16'(tim.vds_filter_time));
      chk(16'(seq_bad), 16'h0000);
      chk(16'(eon), 16'(ON_DLY));
      run_edge(1'b0);
      chk(16'(dur[AHPG_SYM]), afw ? 16'(tim.fw_guard_time) : 16'h0000);
      chk(16'(dur[AHPG_PDCHG]), 16'(tim.predischarge_duration));
      chk(16'(dur[AHPG_PDCHG] + dur[AHPG_DCHG]), 16'(tim.active_guard_time));
      chk(16'(pd_seen), 16'(exp_pd));
      chk(16'(dc_seen), 16'(cur.discharge_current));
      chk(16'(seq_bad), 16'h0000);
      chk(16'(fw_seen), 16'(afw));
      chk(16'(eoff), 16'(OFF_DLY));
   endtask

   task automatic sc_reset();
      chk(16'(gate), 16'h0000);
      chk(16'(phase), 16'h0000);
      chk(16'({pc, pd}), 16'h0000);
   endtask

   task automatic sc_unfiltered();
      set_cfg(1'b1, 2'b10, 1'b0, 1'b0);
      load_codes(6'h30, 6'h05);
      load_codes(6'h10, 6'h05);
      pwm_cycle(LONG_T, LONG_T);
      expect_codes(1, 1);
      set_cfg(1'b1, 2'b10, 1'b0, 1'b1);
      pwm_cycle(SHORT_T, SHORT_T);
      expect_codes(-1, -1);
   endtask

   // A load clears the history, so only the second long delay may move the codes.
   task automatic sc_filtered();
      set_cfg(1'b1, 2'b10, 1'b1, 1'b1);
      load_codes(6'h10, 6'h08);
      pwm_cycle(LONG_T, LONG_T);
      expect_codes(0, 0);
      pwm_cycle(LONG_T, LONG_T);
      expect_codes(1, 1);
   endtask

   task automatic sc_modes();
      for (int m = 1; m < 4; m++) begin
         set_cfg(1'b1, 2'(m), 1'b0, 1'b0);
         load_codes(6'h10, 6'h08);
         pwm_cycle(LONG_T, LONG_T);
         expect_codes(m / 2, m / 2);
      end
   endtask

   task automatic sc_clamp();
      set_cfg(1'b1, 2'b11, 1'b0, 1'b1);
      load_codes(6'h30, 6'h01);
      pwm_cycle(LONG_T, SHORT_T);
      expect_codes(1, -1);
   endtask

   task automatic sc_passive();
      set_cfg(1'b0, 2'b10, 1'b0, 1'b0);
      load_codes(6'h10, 6'h08);
      pwm_cycle(SHORT_T, SHORT_T);
      expect_codes(-1, -1);
   endtask

   // Pre-discharge is kept shorter than the active guard, pre-charge short as well.
   initial begin
      rst = 1'b1;
      pwm = 1'b0;
      en_set = 1'b0;
      afw = 1'b1;
      mode = 2'b10;
      filt = 1'b0;
      step = 1'b0;
      tim = '{12'h004, 12'h014, 12'h005, 12'h004, 12'h006, SHORT_T, SHORT_T};
      cur = '{6'h10, 6'h12, 6'h08, 6'h20, 6'h10, 6'h08};
      repeat (10) @(negedge clk);
      rst = 1'b0;
      @(posedge clk);
      #1;
      sc_reset();
      sc_unfiltered();
      sc_filtered();
      sc_modes();
      sc_clamp();
      sc_passive();
      wrap_up();
   end
endmodule
